/* hw/rvlc_pkg.sv */
// Purpose: Shared constants and types for ROM vector and lookup control
// Assumes: 2K-word program ROM, 8-bit data path
// Notes: Flag bit positions and command layout are local choices

package rvlc_pkg;

	// ****************************************
	// Program memory map
	// ****************************************
	localparam int PC_W = 11;
	localparam logic [10:0] RESET_VEC = 11'h000;
	localparam logic [10:0] IRQ_VEC = 11'h008;
	localparam logic [10:0] USER_START = 11'h009;
	localparam logic [10:0] USER_TOP = 11'h7FC;
	localparam logic [10:0] RESERVED_TOP = 11'h7FF;
	localparam logic [10:0] PC_ONE = 11'h001;

	// ****************************************
	// Stack and flags
	// ****************************************
	localparam int STACK_DEPTH = 4;
	localparam int TMO_BIT = 7;
	localparam int PWD_BIT = 6;
	localparam int CTX_W = 6;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [5:0] FLAG_RST = 6'h00;
	localparam logic [7:0] Z_ONE = 8'h01;
	// Cause pairs as {timeout, power_down}
	localparam logic [1:0] CAUSE_POR = 2'h2;
	localparam logic [1:0] CAUSE_WDT = 2'h0;
	localparam logic [1:0] CAUSE_EXT = 2'h3;

	// ****************************************
	// Sequencer commands and visible state
	// ****************************************
	typedef struct packed {
		logic step;
		logic jump;
		logic call;
		logic ret;
		logic irq_take;
		logic return_from_irq_instruction;
		logic ctx_save;
		logic ctx_restore;
		logic lookup;
		logic z_inc;
		logic wr_acc;
		logic wr_program_flag_register;
		logic wr_y;
		logic wr_z;
		logic [10:0] target;
		logic [7:0] wdata;
	} rvlc_cmd_t;

	typedef struct packed {
		logic [7:0] working_value;
		logic [7:0] high_byte;
		logic [7:0] program_flag_register;
		logic [7:0] mid_addr;
		logic [7:0] low_addr;
	} rvlc_state_t;

endpackage : rvlc_pkg

/* hw/rvlc_stack.sv */
// Purpose: Return-address stack with circular pointer
// Assumes: Push and pop never requested together
// Notes: Overflow wraps over the oldest entry

`timescale 1ns/10ps

module rvlc_stack #(
	parameter int DEPTH = rvlc_pkg::STACK_DEPTH,
	parameter int W = rvlc_pkg::PC_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic clr,
	// Stack access
	input wire logic push,
	input wire logic pop,
	input wire logic [W-1:0] push_data,
	output logic [W-1:0] top
);

	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
		$error("Stack depth must be a power of two");
	end

	logic [PW-1:0] ptr_r;
	logic [PW-1:0] ptr_nxt;
	logic [PW-1:0] top_idx;
	logic [W-1:0] mem_r [DEPTH];

	assign top_idx = ptr_r - PW'(1);
	assign top = mem_r[top_idx];
	assign ptr_nxt = clr ? '0 : push ? ptr_r + PW'(1) : pop ? top_idx : ptr_r;

	always_ff @(posedge sys_clk) begin
		ptr_r <= ptr_nxt;
	end

	// ****************************************
	// Entry storage
	// ****************************************
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		wire logic wr_here = push && !clr && (ptr_r == PW'(i));
		always_ff @(posedge sys_clk) begin
			if (clr)
				mem_r[i] <= '0;
			else if (wr_here)
				mem_r[i] <= push_data;
		end
	end

endmodule : rvlc_stack

/* hw/rvlc_core.sv */
// Purpose: Program counter, vectors, reset cause, context buffer, ROM lookup
// Assumes: Sequencer issues one-cycle commands; ROM read data valid same cycle

`timescale 1ns/10ps

module rvlc_core #(
	parameter bit IRQ_FALLING = 1'b1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Reset sources
	input wire logic ext_rst_n_pin,
	input wire logic wdt_ovf,
	// Interrupt pin
	input wire logic ext_irq_pin,
	// Sequencer
	input wire rvlc_pkg::rvlc_cmd_t cmd,
	output logic irq_req,
	output logic [10:0] program_counter,
	output logic reserved_fetch,
	output logic in_reset,
	// ROM lookup
	output logic [15:0] lookup_addr,
	input wire logic [15:0] rom_data,
	// Visible registers
	output rvlc_pkg::rvlc_state_t state
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic rst_s1_r;
	logic rst_s2_r;
	logic irq_s1_r;
	logic irq_s2_r;
	logic irq_s3_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= 1'b1;
		end else begin
			rst_s1_r <= ext_rst_n_pin;
			rst_s2_r <= rst_s1_r;
		end
	end

	always_ff @(posedge sys_clk) begin
		irq_s1_r <= ext_irq_pin;
		irq_s2_r <= irq_s1_r;
		irq_s3_r <= irq_s2_r;
	end

	wire logic ext_rst = !rst_s2_r;
	wire logic rst_any = sys_rst || ext_rst || wdt_ovf;
	wire logic irq_edge = IRQ_FALLING ? (irq_s3_r && !irq_s2_r) : (!irq_s3_r && irq_s2_r);

	// ****************************************
	// Registers
	// ****************************************
	logic [10:0] pc_r;
	logic [10:0] pc_nxt;
	logic [1:0] cause_r;
	logic [1:0] cause_nxt;
	logic [5:0] flag_r;
	logic [5:0] flag_nxt;
	logic [7:0] acc_r;
	logic [7:0] acc_nxt;
	logic [7:0] hbyte_r;
	logic [7:0] hbyte_nxt;
	logic [7:0] y_r;
	logic [7:0] y_nxt;
	logic [7:0] z_r;
	logic [7:0] z_nxt;
	logic [7:0] ctx_acc_r;
	logic [7:0] ctx_acc_nxt;
	logic [5:0] ctx_flag_r;
	logic [5:0] ctx_flag_nxt;
	logic irq_req_r;
	logic irq_req_nxt;
	logic [10:0] stack_top;

	// ****************************************
	// Program counter and stack
	// ****************************************
	wire logic [10:0] pc_inc = pc_r + rvlc_pkg::PC_ONE;
	wire logic stk_push = !rst_any && (cmd.irq_take || cmd.call);
	wire logic stk_pop = !rst_any && (cmd.return_from_irq_instruction || cmd.ret);
	wire logic [10:0] stk_data = cmd.irq_take ? pc_r : pc_inc;

	assign pc_nxt = rst_any ? rvlc_pkg::RESET_VEC :
		cmd.irq_take ? rvlc_pkg::IRQ_VEC :
		stk_pop ? stack_top :
		(cmd.jump || cmd.call) ? cmd.target :
		cmd.step ? pc_inc : pc_r;

	rvlc_stack #(
		.DEPTH(rvlc_pkg::STACK_DEPTH),
		.W(rvlc_pkg::PC_W)
	) u_stack (
		.sys_clk(sys_clk),
		.clr(rst_any),
		.push(stk_push),
		.pop(stk_pop),
		.push_data(stk_data),
		.top(stack_top)
	);

	// ****************************************
	// Reset cause and flags
	// ****************************************
	assign cause_nxt = sys_rst ? rvlc_pkg::CAUSE_POR :
		ext_rst ? rvlc_pkg::CAUSE_EXT :
		wdt_ovf ? rvlc_pkg::CAUSE_WDT : cause_r;
	assign flag_nxt = rst_any ? rvlc_pkg::FLAG_RST :
		cmd.ctx_restore ? ctx_flag_r :
		cmd.wr_program_flag_register ? cmd.wdata[rvlc_pkg::CTX_W-1:0] : flag_r;

	// ****************************************
	// Context buffer and data registers
	// ****************************************
	assign ctx_acc_nxt = rst_any ? rvlc_pkg::DATA_RST : cmd.ctx_save ? acc_r : ctx_acc_r;
	assign ctx_flag_nxt = rst_any ? rvlc_pkg::FLAG_RST : cmd.ctx_save ? flag_r : ctx_flag_r;
	assign acc_nxt = rst_any ? rvlc_pkg::DATA_RST :
		cmd.lookup ? rom_data[7:0] :
		cmd.ctx_restore ? ctx_acc_r :
		cmd.wr_acc ? cmd.wdata : acc_r;
	assign hbyte_nxt = rst_any ? rvlc_pkg::DATA_RST : cmd.lookup ? rom_data[15:8] : hbyte_r;
	assign y_nxt = rst_any ? rvlc_pkg::DATA_RST : cmd.wr_y ? cmd.wdata : y_r;
	assign z_nxt = rst_any ? rvlc_pkg::DATA_RST : cmd.wr_z ? cmd.wdata : cmd.z_inc ? z_r + rvlc_pkg::Z_ONE : z_r;
	assign irq_req_nxt = rst_any ? 1'b0 : irq_edge ? 1'b1 : cmd.irq_take ? 1'b0 : irq_req_r;

	always_ff @(posedge sys_clk) begin
		pc_r <= pc_nxt;
		cause_r <= cause_nxt;
		flag_r <= flag_nxt;
		irq_req_r <= irq_req_nxt;
	end

	always_ff @(posedge sys_clk) begin
		acc_r <= acc_nxt;
		hbyte_r <= hbyte_nxt;
		y_r <= y_nxt;
		z_r <= z_nxt;
		ctx_acc_r <= ctx_acc_nxt;
		ctx_flag_r <= ctx_flag_nxt;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign program_counter = pc_r;
	assign reserved_fetch = (pc_r > rvlc_pkg::USER_TOP) && (pc_r <= rvlc_pkg::RESERVED_TOP);
	assign in_reset = rst_any;
	assign irq_req = irq_req_r;
	assign lookup_addr = {y_r, z_r};
	assign state.working_value = acc_r;
	assign state.high_byte = hbyte_r;
	assign state.program_flag_register = {cause_r, flag_r};
	assign state.mid_addr = y_r;
	assign state.low_addr = z_r;

	// ****************************************
	// Assertions
	// ****************************************
	pc_reset_vec_a: assert property (@(posedge sys_clk) rst_any |=> pc_r == rvlc_pkg::RESET_VEC)
		else $error("Reset did not load the reset vector");
	por_cause_a: assert property (@(posedge sys_clk) sys_rst |=> state.program_flag_register[7:6] == 2'h2)
		else $error("Power-on cause flags wrong");
	wdt_cause_a: assert property (@(posedge sys_clk) (!sys_rst && !ext_rst && wdt_ovf) |=> cause_r == 2'h0)
		else $error("Watchdog cause flags wrong");
	ext_cause_a: assert property (@(posedge sys_clk) (!sys_rst && ext_rst) |=> cause_r == 2'h3)
		else $error("External cause flags wrong");
	irq_vector_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmd.irq_take && !rst_any) |=> (pc_r == 11'h008 && stack_top == $past(pc_r)))
		else $error("Interrupt entry did not vector and save");
	return_from_irq_instruction_resume_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmd.return_from_irq_instruction && !rst_any && !cmd.irq_take) |=> pc_r == $past(stack_top))
		else $error("Return did not resume at saved address");
	ctx_cause_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmd.ctx_restore && !rst_any) |=> (cause_r == $past(cause_r) && flag_r == $past(ctx_flag_r)))
		else $error("Context restore touched cause bits");
	lookup_split_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmd.lookup && !rst_any) |=> ({hbyte_r, acc_r} == $past(rom_data)))
		else $error("Lookup bytes misplaced");
	z_no_carry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmd.z_inc && !cmd.wr_y && !cmd.wr_z && !rst_any && z_r == 8'hFF)
		|=> (z_r == 8'h00 && y_r == $past(y_r)))
		else $error("Low address carried into middle");
	irq_capture_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(irq_edge && !rst_any) |=> irq_req_r)
		else $error("Pin edge lost");
	reserved_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(pc_r >= 11'h7FD) |-> reserved_fetch)
		else $error("Reserved fetch not flagged");
	user_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(pc_r == 11'h008 && cmd.step && !rst_any && !cmd.irq_take
		&& !cmd.ret && !cmd.return_from_irq_instruction && !cmd.jump && !cmd.call) |=> pc_r == rvlc_pkg::USER_START)
		else $error("Vector area not followed by user space");
	rst_defaults_a: assert property (@(posedge sys_clk) rst_any |=> (flag_r == rvlc_pkg::FLAG_RST
		&& acc_r == rvlc_pkg::DATA_RST && y_r == rvlc_pkg::DATA_RST && z_r == rvlc_pkg::DATA_RST))
		else $error("Reset left a register dirty");
	call_push_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmd.call && !cmd.irq_take && !cmd.ret && !cmd.return_from_irq_instruction && !rst_any) |=> stack_top == $past(pc_inc))
		else $error("Call did not save the return address");
	irq_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmd.irq_take && !irq_edge && !rst_any) |=> !irq_req_r)
		else $error("Taken interrupt still requested");

endmodule : rvlc_core

/* tb/rvlc_rom_model.sv */
// Purpose: Program ROM seen by the lookup path
// Assumes: Word valid in the same cycle as its address
// Notes: Contents are a fixed mix of the address bytes

`timescale 1ns/10ps

module rvlc_rom_model (
	// Lookup port
	input wire logic [15:0] addr,
	output logic [15:0] data
);
	// ****************************************
	// Word contents
	// ****************************************
	// High and low bytes differ so a swapped split shows
	assign data = {addr[7:0] ^ 8'h5A, addr[15:8] ^ 8'hC3};
endmodule : rvlc_rom_model

/* tb/rvlc_core_tb.sv */
// Purpose: Self-checking bench for rvlc_core
// Assumes: Inputs driven at falling edge
// Notes: Sequencer commands issued by hand

`timescale 1ns/10ps

module rvlc_core_tb;
	// ****************************************
	// Signals
	// ****************************************
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ext_rst_n_pin = 1'b1;
	logic wdt_ovf = 1'b0;
	logic ext_irq_pin = 1'b1;
	rvlc_pkg::rvlc_cmd_t cmd = '0;
	logic irq_req;
	logic [10:0] program_counter;
	logic reserved_fetch;
	logic in_reset;
	logic [15:0] lookup_addr;
	logic [15:0] rom_data;
	rvlc_pkg::rvlc_state_t state;
	int errors = 0;
	int n_compared = 0;
	localparam int STEP = 0, JMP = 1, CALL = 2, RET = 3, TAKE = 4, RETURN_FROM_IRQ_INSTRUCTION = 5, SAVE = 6, REST = 7;
	localparam int LOOK = 8, ZINC = 9, WACC = 10, WFLG = 11, WY = 12, WZ = 13;

	always #20 sys_clk = ~sys_clk;

	rvlc_core dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .ext_rst_n_pin(ext_rst_n_pin), .wdt_ovf(wdt_ovf),
		.ext_irq_pin(ext_irq_pin), .cmd(cmd), .irq_req(irq_req), .program_counter(program_counter),
		.reserved_fetch(reserved_fetch), .in_reset(in_reset), .lookup_addr(lookup_addr),
		.rom_data(rom_data), .state(state)
	);

	rvlc_rom_model rom (.addr(lookup_addr), .data(rom_data));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	// One strobe for one cycle, result visible on return
	task automatic op(input int k, input logic [10:0] t, input logic [7:0] d);
		rvlc_pkg::rvlc_cmd_t c;
		c = '0;
		c[32-k] = 1'b1;
		c.target = t;
		c.wdata = d;
		@(negedge sys_clk);
		cmd = c;
		@(negedge sys_clk);
		cmd = '0;
	endtask : op

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_ctx();
		op(WFLG, 11'h000, 8'hFF);
		chk(state.program_flag_register, 16'h00BF);
		op(WACC, 11'h000, 8'h5C);
		op(SAVE, 11'h000, 8'h00);
		op(WFLG, 11'h000, 8'h00);
		op(WACC, 11'h000, 8'h11);
		op(REST, 11'h000, 8'h00);
		chk(state.working_value, 16'h005C);
		chk(state.program_flag_register, 16'h00BF);
		$display("context test done");
	endtask : t_ctx

	task automatic t_look();
		op(WY, 11'h000, 8'h07);
		op(WZ, 11'h000, 8'hFF);
		chk(lookup_addr, 16'h07FF);
		op(LOOK, 11'h000, 8'h00);
		chk(state.working_value, 16'h00C4);
		chk(state.high_byte, 16'h00A5);
		op(ZINC, 11'h000, 8'h00);
		chk(state.low_addr, 16'h0000);
		chk(state.mid_addr, 16'h0007);
		$display("lookup test done");
	endtask : t_look

	task automatic t_stack();
		op(JMP, 11'h010, 8'h00);
		for (int i = 1; i <= 4; i++) begin
			op(CALL, 11'(i << 8), 8'h00);
		end
		chk(program_counter, 16'h0400);
		for (int i = 3; i >= 0; i--) begin
			op(RET, 11'h000, 8'h00);
			chk(program_counter, (i == 0) ? 16'h0011 : 16'((i << 8) + 1));
		end
		$display("stack test done");
	endtask : t_stack

	task automatic t_irq();
		int n;
		op(JMP, 11'h123, 8'h00);
		@(negedge sys_clk);
		ext_irq_pin = 1'b0;
		n = 0;
		while (irq_req !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		if (irq_req !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t interrupt request never rose", $time);
			end_sim();
		end
		chk(irq_req, 16'h0001);
		op(TAKE, 11'h000, 8'h00);
		chk(program_counter, 16'h0008);
		chk(irq_req, 16'h0000);
		op(STEP, 11'h000, 8'h00);
		chk(program_counter, 16'h0009);
		ext_irq_pin = 1'b1;
		op(RETURN_FROM_IRQ_INSTRUCTION, 11'h000, 8'h00);
		chk(program_counter, 16'h0123);
		$display("interrupt test done");
	endtask : t_irq

	task automatic t_rsv();
		op(JMP, 11'h7FC, 8'h00);
		chk(reserved_fetch, 16'h0000);
		op(JMP, 11'h7FD, 8'h00);
		chk(reserved_fetch, 16'h0001);
		op(JMP, 11'h7FF, 8'h00);
		chk(reserved_fetch, 16'h0001);
		$display("reserved test done");
	endtask : t_rsv

	task automatic t_rst();
		op(JMP, 11'h055, 8'h00);
		op(WFLG, 11'h000, 8'h3F);
		// Pin idles high, low requests reset
		ext_rst_n_pin = 1'b0;
		repeat (4) @(negedge sys_clk);
		chk(in_reset, 16'h0001);
		ext_rst_n_pin = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk(in_reset, 16'h0000);
		chk(program_counter, 16'h0000);
		chk(state.working_value, 16'h0000);
		chk(state.high_byte, 16'h0000);
		chk(lookup_addr, 16'h0000);
		chk(state.program_flag_register, 16'h00C0);
		op(JMP, 11'h055, 8'h00);
		wdt_ovf = 1'b1;
		@(negedge sys_clk);
		wdt_ovf = 1'b0;
		@(negedge sys_clk);
		chk(program_counter, 16'h0000);
		chk(state.program_flag_register, 16'h0000);
		$display("reset cause test done");
	endtask : t_rst

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (5) @(negedge sys_clk);
		sys_rst = 1'b0;
		chk(program_counter, 16'h0000);
		chk(state.program_flag_register, 16'h0080);
		$display("power-on test done");
		t_ctx();
		t_look();
		t_stack();
		t_irq();
		t_rsv();
		t_rst();
		end_sim();
	end
endmodule : rvlc_core_tb
